// ### hw/iso_rx_mask_regs.vh
// register offsets, field layouts and reset values for the receive mask
// and startup bandwidth slice; definitions only
`ifndef ISO_RX_MASK_REGS_VH
`define ISO_RX_MASK_REGS_VH

`define OFS_RX_EVENT_SET      8'ha0
`define OFS_RX_EVENT_CLEAR    8'ha4
`define OFS_RX_ENABLE_SET     8'ha8
`define OFS_RX_ENABLE_CLEAR   8'hac
`define OFS_BW_BUDGET         8'hb0
`define OFS_IRQ_STATUS        8'hc0
`define OFS_IRQ_MASK          8'hc4
`define OFS_CTRL              8'hc8

`define RX_CTX_NUM            4
`define BW_FIELD_W            13
`define BW_FIELD_RESET        13'h1333
`define AGG_RX_BIT            7

`define ST_BIT_AGG_RX         0
`define ST_BIT_BW_LOAD        1
`define ST_W                  2
`define CTRL_BIT_SOFT_RESET   0
`endif

// ### hw/rx_ctx_bit.v
// one receive context: event bit, enable bit and its gated contribution
// assumes set/clear strobes are one-cycle pulses on clk_i
`timescale 1ns/10ps
`default_nettype none
module rx_ctx_bit
(
   // clock and reset
   input  wire clk_i,
   input  wire rst_i,
   // event source and software strobes
   input  wire evt_i,
   input  wire evt_set_i,
   input  wire evt_clr_i,
   input  wire en_set_i,
   input  wire en_clr_i,
   // state
   output reg  evt_o,
   output reg  en_o,
   output wire gated_o
);
   reg evt_d_r;

   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         evt_o   <= 1'b0;
         en_o    <= 1'b0;
         evt_d_r <= 1'b0;
      end
      else
      begin
         evt_d_r <= evt_i;
         // a rising edge in the clearing cycle still sets the bit
         if ((evt_i && !evt_d_r) || evt_set_i)
            evt_o <= 1'b1;
         else if (evt_clr_i)
            evt_o <= 1'b0;
         // set address and clear address both act on the same bit
         if (en_set_i)
            en_o <= 1'b1; // R6
         else if (en_clr_i)
            en_o <= 1'b0; // R6
      end
   end

   assign gated_o = evt_o & en_o; // R1 R3

endmodule
`default_nettype wire

// ### hw/bw_budget_reg.v
// startup bandwidth field with reset default and bus-management load
// assumes bus reset and reset inputs are synchronous pulses or levels
`timescale 1ns/10ps
`default_nettype none
`include "iso_rx_mask_regs.vh"
module bw_budget_reg
#(
   parameter W = `BW_FIELD_W
)
(
   // clock and resets
   input  wire         clk_i,
   input  wire         ctl_reset_i,
   // software write
   input  wire         wr_i,
   input  wire [W-1:0] wdata_i,
   // load triggers
   input  wire         load_i,
   // outputs
   output reg  [W-1:0] field_o,
   output reg  [W-1:0] csr_o,
   output reg          loaded_o
);
   always @(posedge clk_i)
   begin
      if (ctl_reset_i)
         field_o <= `BW_FIELD_RESET; // R8
      else if (wr_i)
         field_o <= wdata_i; // R9
      loaded_o <= load_i;
      // the csr copy takes the field value current at the load edge
      if (load_i)
         csr_o <= field_o; // R10
   end
   initial csr_o = {W{1'b0}};
endmodule
`default_nettype wire

// ### hw/iso_rx_mask_and_init_bandwidth.v
// What this block does
// R1: each enable bit gates its receive context into the aggregate receive interrupt
// R2: reads at enable set or clear address return the enable bits, no side effect
// R3: enable bit n governs receive context n, same position as event bit n
// R4: four receive contexts in bits 3..0 raise aggregate bit 7
// R5: event clear address reads event bits ANDed with enable bits
// R6: write one sets at set address, clears at clear address; zeros ignored
// R7: bandwidth register bits above the 13-bit field read zero, ignore writes
// R8: bandwidth field resets to 1333h on hardware or software reset
// R9: a bus reset leaves the stored bandwidth field unchanged
// R10: global, power or bus reset copies field into bandwidth available csr
//
// classic wishbone slave, 32-bit data, byte addresses, one wait state
// assumes all inputs synchronous to clk_i
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "iso_rx_mask_regs.vh"
module iso_rx_mask_and_init_bandwidth
#(
   parameter N  = `RX_CTX_NUM,
   parameter BW = `BW_FIELD_W
)
(
   // clock and reset
   input  wire          clk_i,
   input  wire          rst_i,
   // wishbone slave
   input  wire          cyc_i,
   input  wire          stb_i,
   input  wire          we_i,
   input  wire [7:0]    adr_i,
   input  wire [3:0]    sel_i,
   input  wire [31:0]   dat_i,
   output reg  [31:0]   dat_o,
   output reg           ack_o,
   // receive context events and resets
   input  wire [N-1:0]  rx_ctx_event_i,
   input  wire          global_reset_input_i,
   input  wire          power_reset_input_i,
   input  wire          bus_reset_i,
   // results
   output reg           aggregate_iso_receive_irq_o,
   output reg  [31:0]   main_event_rx_o,
   output reg  [BW-1:0] bandwidth_available_csr_o,
   output reg           irq_o
);
   ////////////////////////////////////////////////////////////////////////
   // bus decode
   wire       req_w  = cyc_i & stb_i & ~ack_o;
   wire       wr_w   = req_w & we_i;
   wire       lo_w   = sel_i[0];
   wire       hi_w   = sel_i[1];
   wire       wr_es  = wr_w & lo_w & (adr_i == `OFS_RX_EVENT_SET);
   wire       wr_ec  = wr_w & lo_w & (adr_i == `OFS_RX_EVENT_CLEAR);
   wire       wr_ns  = wr_w & lo_w & (adr_i == `OFS_RX_ENABLE_SET);
   wire       wr_nc  = wr_w & lo_w & (adr_i == `OFS_RX_ENABLE_CLEAR);
   wire       wr_bw  = wr_w & (adr_i == `OFS_BW_BUDGET);
   wire       wr_st  = wr_w & lo_w & (adr_i == `OFS_IRQ_STATUS);
   wire       wr_mk  = wr_w & lo_w & (adr_i == `OFS_IRQ_MASK);
   wire       wr_ct  = wr_w & lo_w & (adr_i == `OFS_CTRL);

   reg        soft_reset_r;
   wire       ctl_reset_w = rst_i | soft_reset_r;

   ////////////////////////////////////////////////////////////////////////
   // receive contexts
   wire [N-1:0] evt_w;
   wire [N-1:0] en_w;
   wire [N-1:0] gated_w;
   genvar g;
   generate
      for (g = 0; g < N; g = g + 1)
      begin : ctx
         rx_ctx_bit u_bit
         (
            .clk_i     (clk_i),
            .rst_i     (ctl_reset_w),
            .evt_i     (rx_ctx_event_i[g]),
            .evt_set_i (wr_es & dat_i[g]),
            .evt_clr_i (wr_ec & dat_i[g]),
            .en_set_i  (wr_ns & dat_i[g]),
            .en_clr_i  (wr_nc & dat_i[g]),
            .evt_o     (evt_w[g]),
            .en_o      (en_w[g]),
            .gated_o   (gated_w[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // bandwidth field; byte lanes 0 and 1 cover the 13 bits
   wire [BW-1:0] bw_field_w;
   wire [BW-1:0] bw_csr_w;
   wire          bw_loaded_w;
   wire [BW-1:0] bw_wdata_w;
   // partial byte writes keep the untouched lane
   assign bw_wdata_w = {hi_w ? dat_i[BW-1:8] : bw_field_w[BW-1:8],
                        lo_w ? dat_i[7:0]    : bw_field_w[7:0]}; // R7
   wire bw_load_w = global_reset_input_i | power_reset_input_i | bus_reset_i; // R10

   bw_budget_reg #(.W(BW)) u_bw
   (
      .clk_i       (clk_i),
      .ctl_reset_i (ctl_reset_w),
      .wr_i        (wr_bw & (lo_w | hi_w)),
      .wdata_i     (bw_wdata_w),
      .load_i      (bw_load_w),
      .field_o     (bw_field_w),
      .csr_o       (bw_csr_w),
      .loaded_o    (bw_loaded_w)
   );

   ////////////////////////////////////////////////////////////////////////
   // interrupt status and mask; write one to clear, set wins
   reg  [`ST_W-1:0] st_r;
   reg  [`ST_W-1:0] mk_r;
   wire             agg_w = |gated_w; // R1 R4
   reg              agg_d_r;
   wire [`ST_W-1:0] ev_w;
   assign ev_w[`ST_BIT_AGG_RX]  = agg_w & ~agg_d_r;
   assign ev_w[`ST_BIT_BW_LOAD] = bw_loaded_w;

   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_r         <= {`ST_W{1'b0}};
         mk_r         <= {`ST_W{1'b0}};
         agg_d_r      <= 1'b0;
         soft_reset_r <= 1'b0;
      end
      else
      begin
         agg_d_r      <= agg_w;
         st_r         <= (st_r & ~(wr_st ? dat_i[`ST_W-1:0] : {`ST_W{1'b0}})) | ev_w;
         soft_reset_r <= wr_ct & dat_i[`CTRL_BIT_SOFT_RESET];
         if (wr_mk)
            mk_r <= dat_i[`ST_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux; reads have no side effect
   reg [31:0] rd_nxt;
   always @*
   begin
      rd_nxt = 32'h00000000;
      case (adr_i)
         `OFS_RX_EVENT_SET    : rd_nxt[N-1:0] = evt_w;
         `OFS_RX_EVENT_CLEAR  : rd_nxt[N-1:0] = evt_w & en_w; // R5
         `OFS_RX_ENABLE_SET   : rd_nxt[N-1:0] = en_w; // R2
         `OFS_RX_ENABLE_CLEAR : rd_nxt[N-1:0] = en_w; // R2
         `OFS_BW_BUDGET       : rd_nxt[BW-1:0] = bw_field_w; // R7
         `OFS_IRQ_STATUS      : rd_nxt[`ST_W-1:0] = st_r;
         `OFS_IRQ_MASK        : rd_nxt[`ST_W-1:0] = mk_r;
         default              : rd_nxt = 32'h00000000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // registered outputs
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o                       <= 1'b0;
         dat_o                       <= 32'h00000000;
         aggregate_iso_receive_irq_o <= 1'b0;
         main_event_rx_o             <= 32'h00000000;
         bandwidth_available_csr_o   <= {BW{1'b0}};
         irq_o                       <= 1'b0;
      end
      else
      begin
         // unmapped addresses still ack, reading zero
         ack_o                       <= req_w;
         dat_o                       <= req_w ? rd_nxt : 32'h00000000;
         aggregate_iso_receive_irq_o <= agg_w; // R1
         main_event_rx_o             <= {24'h000000, agg_w, 7'h00}; // R4
         bandwidth_available_csr_o   <= bw_csr_w; // R10
         irq_o                       <= |((st_r | ev_w) & mk_r);
      end
   end

endmodule
`default_nettype wire

// ### bench/iso_rx_mask_monitor.sv
// port assertions for the receive mask and bandwidth slice
// bound into the top module; one clock domain, sync reset
`timescale 1ns/10ps
`default_nettype none
module iso_rx_mask_monitor
#(
   parameter N  = 4,
   parameter BW = 13
)
(
   // bus side
   input wire          clk_i,
   input wire          rst_i,
   input wire          cyc_i,
   input wire          stb_i,
   input wire          we_i,
   input wire [7:0]    adr_i,
   input wire [31:0]   dat_o,
   input wire          ack_o,
   // loads and results
   input wire          global_reset_input_i,
   input wire          power_reset_input_i,
   input wire          bus_reset_i,
   input wire [31:0]   main_event_rx_o,
   input wire [BW-1:0] bandwidth_available_csr_o
);
   wire trig = global_reset_input_i | power_reset_input_i | bus_reset_i;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////
   a_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack held over one cycle");
   a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not acked next cycle");
   a_ack_unasked: assert property (!(cyc_i && stb_i) |=> !ack_o)
      else $error("ack without request");
   a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
      else $error("read data outside ack");
   a_mask_rsvd: assert property (
      ack_o && !$past(we_i) && $past(adr_i) inside {8'ha4, 8'ha8, 8'hac} |-> dat_o[31:4] == 28'h0)
      else $error("mask or event read has upper bits set");
   a_bw_rsvd: assert property (
      ack_o && !$past(we_i) && $past(adr_i) == 8'hb0 |-> dat_o[31:13] == 19'h0)
      else $error("bandwidth read has reserved bits set");
   a_main_rsvd: assert property (
      main_event_rx_o[31:8] == 24'h0 && main_event_rx_o[6:0] == 7'h0)
      else $error("main event bits other than bit 7 set");
   a_csr_cause: assert property (
      $changed(bandwidth_available_csr_o) |-> $past(trig, 2) || $past(rst_i, 2) || $past(rst_i))
      else $error("csr changed without a load");
   c_write: cover property (ack_o && $past(we_i));
   c_read: cover property (ack_o && !$past(we_i));
   c_csr: cover property ($changed(bandwidth_available_csr_o));
endmodule
bind iso_rx_mask_and_init_bandwidth iso_rx_mask_monitor #(.N(N), .BW(BW)) u_mon (.*);
`default_nettype wire

// ### bench/testbench.sv
// self-checking bench for the receive mask and bandwidth slice
// drives the wishbone port and the event and reset inputs itself
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i = 1'b0;
   logic        glb = 1'b0;
   logic        pwr = 1'b0;
   logic        bus = 1'b0;
   logic [7:0]  adr_i = 8'h00;
   logic [3:0]  sel_i = 4'hf;
   logic [3:0]  ev = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o, rd, main_ev;
   logic        ack_o, agg, irq;
   logic [12:0] csr;
   int          n_errors = 0;
   int          samples_checked = 0;

   iso_rx_mask_and_init_bandwidth dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .rx_ctx_event_i(ev), .global_reset_input_i(glb),
      .power_reset_input_i(pwr), .bus_reset_i(bus), .aggregate_iso_receive_irq_o(agg),
      .main_event_rx_o(main_ev), .bandwidth_available_csr_o(csr), .irq_o(irq));

   initial
   begin
      forever #2 clk_i = ~clk_i;
   end
   ////////////////////////////////////////
   task automatic results;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // entered just after a rising edge; leaves one idle cycle behind
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      for (k = 0; k < 20; k++)
      begin
         @(posedge clk_i);
         if (ack_o === 1'b1)
            break;
      end
      if (k == 20)
      begin
         n_errors++;
         results();
      end
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
      wb(1'b0, a, 32'h0);
      chk(rd, exp, what);
   endtask
   ////////////////////////////////////////
   task automatic s_mask;
      rdc(8'hb0, 32'h00001333, "bandwidth default");
      rdc(8'h00, 32'h0, "unmapped read");
      wb(1'b1, 8'ha8, 32'hffffffff);
      rdc(8'ha8, 32'h0000000f, "enable set");
      wb(1'b1, 8'hac, 32'h00000005);
      rdc(8'hac, 32'h0000000a, "enable at clear address");
      rdc(8'ha8, 32'h0000000a, "enable reread");
   endtask

   // each context alone enabled while the other three fire
   task automatic s_gate;
      int n;
      for (n = 0; n < 4; n++)
      begin
         ev <= 4'h0;
         wb(1'b1, 8'hac, 32'hf);
         wb(1'b1, 8'ha4, 32'hf);
         wb(1'b1, 8'ha8, 32'h1 << n);
         ev <= ~(4'h1 << n);
         tick(4);
         chk(agg, 32'h0, "masked contexts");
         rdc(8'ha4, 32'h0, "gated events");
         ev <= 4'hf;
         tick(4);
         chk(agg, 32'h1, "enabled context");
         chk(main_ev, 32'h80, "main event");
         rdc(8'ha4, 32'h1 << n, "gated events");
      end
   endtask

   task automatic s_bw;
      logic [12:0] v [3] = '{13'h0abc, 13'h0123, 13'h1fff};
      int t;
      for (t = 0; t < 3; t++)
      begin
         wb(1'b1, 8'hb0, {19'h7ffff, v[t]});
         rdc(8'hb0, {19'h0, v[t]}, "bandwidth field");
         glb <= (t == 0);
         pwr <= (t == 1);
         bus <= (t == 2);
         tick(1);
         glb <= 1'b0;
         pwr <= 1'b0;
         bus <= 1'b0;
         tick(3);
         chk(csr, {19'h0, v[t]}, "bandwidth csr");
         rdc(8'hb0, {19'h0, v[t]}, "field after load");
      end
   endtask

   task automatic s_irq;
      wb(1'b1, 8'hc0, 32'h3);
      bus <= 1'b1;
      tick(1);
      bus <= 1'b0;
      tick(3);
      chk(irq, 32'h0, "masked irq");
      rdc(8'hc0, 32'h2, "irq status");
      wb(1'b1, 8'hc4, 32'h2);
      tick(2);
      chk(irq, 32'h1, "unmasked irq");
      wb(1'b1, 8'hc0, 32'h2);
      tick(2);
      chk(irq, 32'h0, "cleared irq");
      wb(1'b1, 8'hc8, 32'h1);
      tick(2);
      rdc(8'hb0, 32'h00001333, "field after soft reset");
      rdc(8'ha8, 32'h0, "enable after soft reset");
   endtask

   initial
   begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      s_mask();
      s_gate();
      s_bw();
      s_irq();
      results();
   end
endmodule
`default_nettype wire
